// >>> core/csp_pkg.sv
// Constants, types and register map of the converter sequencing and protection control.
// Assumes one 125 MHz system clock; all analog sense flags arrive as plain levels.
package csp_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SYS_CLK_HZ = 125_000_000;
  localparam int SW_CLK_HZ  = 1_500_000;
  // One switching cycle rounded down to whole system cycles
  localparam int TICK_CYC   = SYS_CLK_HZ / SW_CLK_HZ;
  localparam int OCP_COUNT  = 64;
  localparam int TICK_W     = 7;
  localparam int OCP_W      = 7;
  localparam int STEP_W     = 16;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_MASK     = 8'h08;
  localparam logic [7:0]  ADDR_STATE    = 8'h0c;
  localparam logic [0:0]  CTRL_RST      = 1'h0;
  localparam int          CTRL_HOLD_BIT = 0;
  localparam int          EV_OCP        = 0;
  localparam int          EV_RAIL       = 1;
  localparam int          EV_TSD        = 2;
  localparam int          EV_UVLO       = 3;
  localparam int          EV_CH7OCP     = 4;
  localparam int          EV_OVP        = 5;
  localparam int          EV_W          = 6;
  localparam logic [5:0]  EV_RST        = 6'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  localparam logic [2:0]  MAIN_STEPS = 3'h4;
  localparam logic [1:0]  CCD_STEPS  = 2'h2;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_RUN  = 2'b01,
    ST_DOWN = 2'b11,
    ST_TRIP = 2'b10
  } csp_state_e;

  typedef struct packed {
    logic sleepReleaseN;
    logic afeChannelEnable;
    logic ccdPairEnable;
    logic backlightEnable;
    logic ccdSlopeSelect;
    logic pfmRequest;
  } csp_pins_s;

  typedef struct packed {
    logic       batteryPresent;
    logic       batteryBelowDetect;
    logic       batteryAboveRelease;
    logic       thermalOver;
    logic       ch8Low70;
    logic       ldoLow80;
    logic       ch7OcpOver;
    logic [5:0] ocpOver;
    logic [5:0] outLow80;
    logic [7:0] ovpOver;
  } csp_sense_s;

  typedef struct packed {
    logic       ldoEnable;
    logic       ch8Pfm;
    logic       ch7LoadSwitchOn;
    logic       ch5UsesCcdSlope;
    logic [7:0] chEnable;
  } csp_rails_s;

endpackage : csp_pkg

// >>> core/csp_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes the bits are independent levels; no bundle coherence is promised.
`timescale 1ns/10ps
`default_nettype none
module csp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : csp_sync
`default_nettype wire

// >>> core/csp_ctrl.sv
// Power-up/down sequencing and protection reactions of the eight-channel converter.
// Assumes pins and analog comparators are asynchronous; an AXI4-Lite master on clk.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Sleep-release low keeps all rails off; high runs ch1-3, LDO and ch8, enables gate ch4-7.
// - Sleep-release falling turns everything off through the ordered power-down.
// - Ch1-4 use the main slope; ch5 uses the CCD slope only when the slope select is high.
// - Undervoltage while released shuts all down at once and releases with hysteresis.
// - Ch1-6 overcurrent with low output for 64 switching cycles latches everything off.
// - An overcurrent latch clears on sleep, AFE or CCD enable rising, or battery reapplied.
// - Ch7 overcurrent turns only ch7 off and recovers by itself.
// - Ch8 below 70 percent or the LDO below 80 percent latches everything off.
// - That rail latch clears on sleep or AFE enable rising, or battery reapplied.
// - Overvoltage turns off that channel only, recovering when feedback drops.
// - Ch7 overvoltage turns its switch off and its load switch on.
// - Overtemperature shuts all down until a sleep, AFE or CCD enable rise or battery reapplied.
module csp_ctrl #(
  parameter int         MAIN_STEP_CYC = 1000,
  parameter int         CCD_STEP_CYC  = 1000,
  parameter logic [2:0] REF_SLOT      = 3'h1,
  parameter logic [2:0] CH1_SLOT      = 3'h2,
  parameter logic [2:0] CH2_SLOT      = 3'h3,
  parameter logic [2:0] CH3_SLOT      = 3'h4,
  parameter logic [1:0] CH5_SLOT      = 2'h1,
  parameter logic [1:0] CH6_SLOT      = 2'h2
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire csp_pkg::csp_pins_s  pins,
  input  wire csp_pkg::csp_sense_s sense,
  output var  csp_pkg::csp_rails_s rails,
  output var  logic                irq,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output var  logic [1:0]          s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  input  wire logic [7:0]          s_axi_araddr,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  csp_pkg::csp_pins_s  pinS;
  csp_pkg::csp_sense_s senseS;
  csp_pkg::csp_pins_s  pinQ_reg;
  logic                batQ_reg;

  csp_sync #(.W($bits(csp_pkg::csp_pins_s))) u_pin_sync (
    .clk(clk), .arst_n(arst_n), .d(pins), .q(pinS));
  csp_sync #(.W($bits(csp_pkg::csp_sense_s))) u_sense_sync (
    .clk(clk), .arst_n(arst_n), .d(sense), .q(senseS));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinQ_reg <= '0;
      batQ_reg <= 1'b0;
    end else begin
      pinQ_reg <= pinS;
      batQ_reg <= senseS.batteryPresent;
    end
  end

  logic sleepRise, afeRise, ccdRise, batRise;
  assign sleepRise = pinS.sleepReleaseN & ~pinQ_reg.sleepReleaseN;
  assign afeRise   = pinS.afeChannelEnable & ~pinQ_reg.afeChannelEnable;
  assign ccdRise   = pinS.ccdPairEnable & ~pinQ_reg.ccdPairEnable;
  assign batRise   = senseS.batteryPresent & ~batQ_reg;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  csp_pkg::csp_state_e     state_reg;
  logic [2:0]              mainStage_reg;
  logic [1:0]              ccdStage_reg;
  logic [csp_pkg::STEP_W-1:0] mainCnt_reg, ccdCnt_reg;
  logic                    ctrlHold_reg;
  logic [csp_pkg::EV_W-1:0] status_reg, mask_reg;
  logic                    uvlo_reg, ocpLatch_reg, railLatch_reg, tsdLatch_reg;
  logic                    running, abrupt, anyLatch, mainFull;

  assign running  = (state_reg == csp_pkg::ST_RUN);
  assign anyLatch = ocpLatch_reg | railLatch_reg | tsdLatch_reg;
  assign abrupt   = anyLatch | uvlo_reg;
  assign mainFull = (mainStage_reg == csp_pkg::MAIN_STEPS);

  // ----------------------------------------
  // Switching-cycle tick and overcurrent qualifiers
  // ----------------------------------------
  logic [csp_pkg::TICK_W-1:0] tick_reg;
  logic                       tick;
  logic [5:0]                 ocpConfirm;
  assign tick = (tick_reg == csp_pkg::TICK_W'(csp_pkg::TICK_CYC - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) tick_reg <= '0;
    else tick_reg <= tick ? '0 : tick_reg + 1'b1;
  end

  for (genvar i = 0; i < 6; i++) begin : g_ocp
    logic [csp_pkg::OCP_W-1:0] cnt_reg;
    logic                      cond;
    assign cond = senseS.ocpOver[i] & senseS.outLow80[i] & rails.chEnable[i];
    // A single good cycle restarts the count, so only a sustained fault trips
    assign ocpConfirm[i] = cond & tick & (cnt_reg == csp_pkg::OCP_W'(csp_pkg::OCP_COUNT - 1));
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) cnt_reg <= '0;
      else if (!cond) cnt_reg <= '0;
      else if (tick && !ocpConfirm[i]) cnt_reg <= cnt_reg + 1'b1;
    end
    chk_ocp_trip: assert property (
      ocpConfirm[i] |=> ocpLatch_reg ##1 rails.chEnable == '0)
      else $error("qualified overcurrent did not latch off");
  end

  // ----------------------------------------
  // Fault latches
  // ----------------------------------------
  logic ocpSet, railSet, tsdSet, uvloSet;
  assign ocpSet  = |ocpConfirm;
  assign railSet = (senseS.ch8Low70 & rails.chEnable[7]) | (senseS.ldoLow80 & rails.ldoEnable);
  assign tsdSet  = senseS.thermalOver & pinS.sleepReleaseN;
  assign uvloSet = pinS.sleepReleaseN & senseS.batteryBelowDetect;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ocpLatch_reg  <= 1'b0;
      railLatch_reg <= 1'b0;
      tsdLatch_reg  <= 1'b0;
      uvlo_reg      <= 1'b0;
    end else begin
      // A new detection in the clearing cycle keeps the latch set
      if (ocpSet) ocpLatch_reg <= 1'b1;
      else if (sleepRise | afeRise | ccdRise | batRise) ocpLatch_reg <= 1'b0;
      if (railSet) railLatch_reg <= 1'b1;
      else if (sleepRise | afeRise | batRise) railLatch_reg <= 1'b0;
      if (tsdSet) tsdLatch_reg <= 1'b1;
      else if (sleepRise | afeRise | ccdRise | batRise) tsdLatch_reg <= 1'b0;
      // Detect and release levels differ, giving the hysteresis band
      if (uvloSet) uvlo_reg <= 1'b1;
      else if (senseS.batteryAboveRelease) uvlo_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state_reg <= csp_pkg::ST_OFF;
    else begin
      unique case (state_reg)
        csp_pkg::ST_OFF:
          if (abrupt) state_reg <= csp_pkg::ST_TRIP;
          else if (pinS.sleepReleaseN && !ctrlHold_reg) state_reg <= csp_pkg::ST_RUN;
        csp_pkg::ST_RUN:
          if (abrupt) state_reg <= csp_pkg::ST_TRIP;
          else if (!pinS.sleepReleaseN || ctrlHold_reg) state_reg <= csp_pkg::ST_DOWN;
        csp_pkg::ST_DOWN:
          if (abrupt) state_reg <= csp_pkg::ST_TRIP;
          else if (mainStage_reg == '0 && ccdStage_reg == '0) state_reg <= csp_pkg::ST_OFF;
        csp_pkg::ST_TRIP:
          if (!abrupt) state_reg <= csp_pkg::ST_OFF;
      endcase
    end
  end

  // Ramp targets; PFM leaves only ch8 running, so the main group steps down
  logic [2:0] mainTarget;
  logic [1:0] ccdTarget;
  assign mainTarget = (running && !pinS.pfmRequest) ? csp_pkg::MAIN_STEPS : 3'h0;
  assign ccdTarget  = (running && mainFull && pinS.ccdPairEnable) ? csp_pkg::CCD_STEPS : 2'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mainStage_reg <= '0;
      mainCnt_reg   <= '0;
    end else if (abrupt) begin
      mainStage_reg <= '0;
      mainCnt_reg   <= '0;
    end else if (mainCnt_reg != '0) begin
      mainCnt_reg <= mainCnt_reg - 1'b1;
    end else if (mainStage_reg != mainTarget) begin
      mainStage_reg <= (mainStage_reg < mainTarget) ? mainStage_reg + 1'b1
                                                    : mainStage_reg - 1'b1;
      mainCnt_reg   <= csp_pkg::STEP_W'(MAIN_STEP_CYC - 1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ccdStage_reg <= '0;
      ccdCnt_reg   <= '0;
    end else if (abrupt) begin
      ccdStage_reg <= '0;
      ccdCnt_reg   <= '0;
    end else if (ccdCnt_reg != '0) begin
      ccdCnt_reg <= ccdCnt_reg - 1'b1;
    end else if (ccdStage_reg != ccdTarget) begin
      ccdStage_reg <= (ccdStage_reg < ccdTarget) ? ccdStage_reg + 1'b1
                                                 : ccdStage_reg - 1'b1;
      ccdCnt_reg   <= csp_pkg::STEP_W'(CCD_STEP_CYC - 1);
    end
  end

  // ----------------------------------------
  // Rail outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rails <= '0;
    else if (abrupt) rails <= '0;
    else begin
      rails.ldoEnable       <= mainStage_reg >= REF_SLOT;
      rails.ch8Pfm          <= running & pinS.pfmRequest;
      rails.ch7LoadSwitchOn <= pinS.sleepReleaseN & senseS.ovpOver[6];
      rails.ch5UsesCcdSlope <= pinS.ccdSlopeSelect;
      rails.chEnable[0] <= (mainStage_reg >= CH1_SLOT) & ~senseS.ovpOver[0];
      rails.chEnable[1] <= (mainStage_reg >= CH2_SLOT) & ~senseS.ovpOver[1];
      rails.chEnable[2] <= (mainStage_reg >= CH3_SLOT) & ~senseS.ovpOver[2];
      rails.chEnable[3] <= running & mainFull & pinS.afeChannelEnable
                           & ~senseS.ovpOver[3];
      rails.chEnable[4] <= (ccdStage_reg >= CH5_SLOT) & ~senseS.ovpOver[4];
      rails.chEnable[5] <= (ccdStage_reg >= CH6_SLOT) & ~senseS.ovpOver[5];
      rails.chEnable[6] <= running & ~pinS.pfmRequest & pinS.backlightEnable
                           & ~senseS.ch7OcpOver & ~senseS.ovpOver[6];
      rails.chEnable[7] <= (running | (mainStage_reg >= REF_SLOT))
                           & ~senseS.ovpOver[7];
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [csp_pkg::EV_W-1:0] events, w1c;
  assign events = {|senseS.ovpOver, senseS.ch7OcpOver & running, uvloSet & ~uvlo_reg,
                   tsdSet, railSet, ocpSet};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= csp_pkg::EV_RST;
      irq        <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~w1c) | events;
      irq        <= |(status_reg & mask_reg);
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic [7:0]  wAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        doWrite;
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign w1c = (doWrite && wAddr_reg == csp_pkg::ADDR_STATUS && wStrb_reg[0])
               ? wData_reg[csp_pkg::EV_W-1:0] : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= csp_pkg::RESP_OKAY;
      wAddr_reg     <= '0;
      wData_reg     <= '0;
      wStrb_reg     <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wAddr_reg     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData_reg    <= s_axi_wdata;
        wStrb_reg    <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wAddr_reg[7:4] == 4'h0 && wAddr_reg[1:0] == 2'h0
                         && wAddr_reg != csp_pkg::ADDR_STATE)
                        ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlHold_reg <= csp_pkg::CTRL_RST;
      mask_reg     <= csp_pkg::EV_RST;
    end else if (doWrite && wStrb_reg[0]) begin
      if (wAddr_reg == csp_pkg::ADDR_CTRL) ctrlHold_reg <= wData_reg[csp_pkg::CTRL_HOLD_BIT];
      if (wAddr_reg == csp_pkg::ADDR_MASK) mask_reg <= wData_reg[csp_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= csp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= csp_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        csp_pkg::ADDR_CTRL:   s_axi_rdata <= {31'h0, ctrlHold_reg};
        csp_pkg::ADDR_STATUS: s_axi_rdata <= {26'h0, status_reg};
        csp_pkg::ADDR_MASK:   s_axi_rdata <= {26'h0, mask_reg};
        csp_pkg::ADDR_STATE:  s_axi_rdata <= {7'h0, tsdLatch_reg, railLatch_reg, ocpLatch_reg,
                                              uvlo_reg, state_reg, ccdStage_reg, mainStage_reg,
                                              5'h0, rails.ldoEnable, rails.chEnable};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= csp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_sleep_off: assert property (
    state_reg == csp_pkg::ST_OFF && $past(state_reg) == csp_pkg::ST_OFF
    && mainStage_reg == '0 |-> rails.chEnable[6:0] == '0)
    else $error("rail on while sequencer is off");
  chk_orderly_down: assert property (
    running && !pinS.sleepReleaseN && !abrupt |=> state_reg == csp_pkg::ST_DOWN)
    else $error("sleep fall did not start power-down");
  chk_abrupt_off: assert property (
    abrupt |=> rails.chEnable == '0 && !rails.ldoEnable && mainStage_reg == '0)
    else $error("fault did not shut all rails at once");
  chk_uvlo_hold: assert property (
    uvlo_reg && !senseS.batteryAboveRelease |=> uvlo_reg)
    else $error("undervoltage released inside hysteresis");
  chk_stage_step: assert property (
    !$past(abrupt) && $changed(mainStage_reg) |-> $past(mainCnt_reg) == '0)
    else $error("main stage moved before its step time");
  chk_ocp_clear: assert property (
    $fell(ocpLatch_reg) |-> $past(sleepRise | afeRise | ccdRise | batRise))
    else $error("overcurrent latch cleared without cause");
  chk_rail_clear: assert property (
    $fell(railLatch_reg) |-> $past(sleepRise | afeRise | batRise))
    else $error("rail latch cleared without cause");
  chk_ch7_ocp: assert property (
    senseS.ch7OcpOver |=> !rails.chEnable[6])
    else $error("ch7 stayed on during overcurrent");
  chk_ovp_off: assert property (
    |senseS.ovpOver |=> (rails.chEnable & $past(senseS.ovpOver)) == '0)
    else $error("channel on during overvoltage");
  chk_load_sw: assert property (
    senseS.ovpOver[6] && pinS.sleepReleaseN && !abrupt |=> rails.ch7LoadSwitchOn)
    else $error("ch7 load switch not on at overvoltage");
  chk_slope_sel: assert property (
    !abrupt ##1 !abrupt |-> rails.ch5UsesCcdSlope == $past(pinS.ccdSlopeSelect))
    else $error("ch5 slope source does not follow select");
  chk_tsd_latch: assert property (
    tsdSet |=> tsdLatch_reg ##1 rails.chEnable == '0)
    else $error("overtemperature did not shut down");

endmodule : csp_ctrl
`default_nettype wire

// >>> tb/csp_host.sv
// Host model: drives the sleep-release and enable pins as a board controller would.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module csp_host (
  input  wire logic                clk,
  input  wire csp_pkg::csp_rails_s rails,
  output var  csp_pkg::csp_pins_s  pins
);
  // ----------------------------------------
  // Pin tasks
  // ----------------------------------------
  initial pins = '0;
  task automatic wake(input logic v);
    pins.sleepReleaseN <= v;
    repeat (3) @(posedge clk);
  endtask : wake
  task automatic loads(input logic [3:0] v);
    int n;
    n = 0;
    // Loads share the main slope, so hold them back until ch1-3 run
    while (v[3:2] != 2'h0 && rails.chEnable[2:0] !== 3'h7 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      tb_top.cmp(n, 0);
      tb_top.end_sim();
    end
    {pins.afeChannelEnable, pins.ccdPairEnable, pins.backlightEnable,
     pins.ccdSlopeSelect} <= v;
    @(posedge clk);
  endtask : loads
  task automatic toggle_afe();
    pins.afeChannelEnable <= 1'b0;
    repeat (4) @(posedge clk);
    pins.afeChannelEnable <= 1'b1;
    @(posedge clk);
  endtask : toggle_afe
  task automatic pfm(input logic v);
    // Entry to the PFM state only from the all-loads-off state
    {pins.afeChannelEnable, pins.ccdPairEnable, pins.backlightEnable} <= 3'h0;
    repeat (4) @(posedge clk);
    pins.pfmRequest <= v;
    @(posedge clk);
  endtask : pfm
endmodule : csp_host
`default_nettype wire

// >>> tb/tb_top.sv
// Bench for the converter sequencing and protection control.
// Assumes csp_pkg is compiled first; sense comparators are driven here.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk, arst_n, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  csp_pkg::csp_pins_s pins;
  csp_pkg::csp_sense_s sense;
  csp_pkg::csp_rails_s rails;
  int bad_count, checks_done;
  // Short step spacing keeps sequencing waits small
  csp_ctrl #(.MAIN_STEP_CYC(4), .CCD_STEP_CYC(4)) csp_ctrl_inst (.clk, .arst_n, .pins, .sense,
    .rails, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  csp_host csp_host_inst (.clk, .rails, .pins);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    forever begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1) break;
      if (n > 50) begin
        cmp(n, 0);
        end_sim();
      end
    end
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'h0;
    @(posedge clk);
  endtask : axi
  task automatic wait_en(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    while ((rails.chEnable & m) !== v) begin
      @(posedge clk);
      n++;
      if (n > 3000) begin
        cmp(rails.chEnable, v);
        end_sim();
      end
    end
  endtask : wait_en
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {bad_count, checks_done, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    sense = '0;
    {sense.batteryPresent, sense.batteryAboveRelease} = 2'h3;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    cmp({rails, irq}, 0);
    for (int i = 0; i < 3; i++) begin
      axi(0, 8'(i * 4), 0);
      cmp({r, q[5:0]}, 0);
    end
    axi(0, 8'h10, 0);
    cmp(r, csp_pkg::RESP_SLVERR);
    axi(1, csp_pkg::ADDR_STATE, 0);
    cmp(r, csp_pkg::RESP_SLVERR);
    axi(1, csp_pkg::ADDR_MASK, 32'h3f);
    csp_host_inst.wake(1);
    wait_en(8'h87, 8'h87);
    cmp({rails.ldoEnable, rails.chEnable[6:3]}, 5'h10);
    csp_host_inst.loads(4'hf);
    wait_en(8'hff, 8'hff);
    cmp(rails.ch5UsesCcdSlope, 1);
    csp_host_inst.loads(4'he);
    repeat (5) @(posedge clk);
    cmp(rails.ch5UsesCcdSlope, 0);
    sense.ovpOver <= 8'hc1;
    repeat (5) @(posedge clk);
    cmp({rails.ch7LoadSwitchOn, rails.chEnable}, 9'h13e);
    cmp(irq, 1);
    sense.ovpOver <= 8'h00;
    wait_en(8'hc1, 8'hc1);
    sense.ch7OcpOver <= 1'b1;
    repeat (5) @(posedge clk);
    cmp(rails.chEnable, 8'hbf);
    sense.ch7OcpOver <= 1'b0;
    wait_en(8'h40, 8'h40);
    axi(0, csp_pkg::ADDR_STATUS, 0);
    cmp(q[5:0], 6'h30);
    axi(1, csp_pkg::ADDR_STATUS, 32'h3f);
    repeat (2) @(posedge clk);
    cmp(irq, 0);
    {sense.ocpOver[0], sense.outLow80[0]} <= 2'h3;
    repeat (62 * csp_pkg::TICK_CYC) @(posedge clk);
    cmp(rails.chEnable, 8'hff);
    wait_en(8'hff, 8'h00);
    cmp(rails.ldoEnable, 0);
    {sense.ocpOver[0], sense.outLow80[0]} <= 2'h0;
    axi(0, csp_pkg::ADDR_STATE, 0);
    cmp(q[22], 1);
    // A write with no byte strobe must leave the mask alone
    s_axi_wstrb <= 4'h0;
    axi(1, csp_pkg::ADDR_MASK, 0);
    s_axi_wstrb <= 4'hf;
    repeat (2) @(posedge clk);
    cmp(irq, 1);
    axi(1, csp_pkg::ADDR_MASK, 0);
    repeat (2) @(posedge clk);
    cmp(irq, 0);
    axi(1, csp_pkg::ADDR_MASK, 32'h3f);
    repeat (2) @(posedge clk);
    cmp(irq, 1);
    axi(1, csp_pkg::ADDR_STATUS, 32'h3f);
    csp_host_inst.toggle_afe();
    wait_en(8'h87, 8'h87);
    sense.ch8Low70 <= 1'b1;
    wait_en(8'hff, 8'h00);
    sense.ch8Low70 <= 1'b0;
    repeat (20) @(posedge clk);
    cmp(rails, 0);
    csp_host_inst.wake(0);
    csp_host_inst.wake(1);
    wait_en(8'h87, 8'h87);
    sense.ldoLow80 <= 1'b1;
    wait_en(8'hff, 8'h00);
    sense.ldoLow80 <= 1'b0;
    repeat (20) @(posedge clk);
    cmp(rails, 0);
    csp_host_inst.toggle_afe();
    wait_en(8'h87, 8'h87);
    sense.thermalOver <= 1'b1;
    wait_en(8'hff, 8'h00);
    sense.thermalOver <= 1'b0;
    repeat (20) @(posedge clk);
    cmp(rails, 0);
    sense.batteryPresent <= 1'b0;
    repeat (4) @(posedge clk);
    sense.batteryPresent <= 1'b1;
    wait_en(8'h87, 8'h87);
    {sense.batteryBelowDetect, sense.batteryAboveRelease} <= 2'h2;
    repeat (5) @(posedge clk);
    cmp(rails, 0);
    sense.batteryBelowDetect <= 1'b0;
    repeat (20) @(posedge clk);
    cmp(rails, 0);
    sense.batteryAboveRelease <= 1'b1;
    wait_en(8'h87, 8'h87);
    axi(1, csp_pkg::ADDR_CTRL, 1);
    wait_en(8'hff, 8'h00);
    axi(0, csp_pkg::ADDR_CTRL, 0);
    cmp(q, 1);
    axi(1, csp_pkg::ADDR_CTRL, 0);
    wait_en(8'h87, 8'h87);
    csp_host_inst.pfm(1);
    wait_en(8'h87, 8'h80);
    // The LDO drops one step after ch1, so let the last step finish
    repeat (8) @(posedge clk);
    cmp({rails.ch8Pfm, rails.ldoEnable}, 2'h2);
    csp_host_inst.pfm(0);
    wait_en(8'h87, 8'h87);
    csp_host_inst.wake(0);
    wait_en(8'h04, 8'h00);
    cmp(rails.chEnable[0], 1);
    wait_en(8'hff, 8'h00);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
